// *** testbench/tb.sv ***
// self-checking bench for the control word and handler priority block
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int unsigned PB = 4;
  localparam logic [7:0] PM = 8'(8'hFF << (8 - PB));
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [11:0] paddr_i = 12'h000;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [31:0] pwdata_i = 32'h00000000;
  logic [3:0] pstrb_i = 4'h0;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic dcache_on_o;
  logic icache_on_o;
  cchp_pkg::cchp_prio_t prio_o;
  cchp_pkg::cchp_core_evt_t evt_i = '0;
  cchp_pkg::cchp_core_act_t act_o;
  cchp_pkg::cchp_stack_req_t stack_req_i = '0;
  logic [31:0] frame_sp_o;
  logic [31:0] stacked_psr_o;
  logic [31:0] restored_sp_o;
  int fail_count = 0;
  int checked = 0;
  logic [31:0] rd;
  logic err;
  cchp_pkg::cchp_core_evt_t ev [9];

  cchp_regs #(.PRIO_BITS(PB)) dut (
    .mclk_i(mclk_i), .rst_i(rst_i), .paddr_i(paddr_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .dcache_on_o(dcache_on_o), .icache_on_o(icache_on_o),
    .prio_o(prio_o), .evt_i(evt_i), .act_o(act_o), .stack_req_i(stack_req_i),
    .frame_sp_o(frame_sp_o), .stacked_psr_o(stacked_psr_o), .restored_sp_o(restored_sp_o)
  );

  always #5 mclk_i = ~mclk_i;

  task automatic end_of_test();
    if (fail_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test

  task automatic cmp(input string what, input logic [47:0] exp, input logic [47:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  // request held from setup edge until the edge that samples pready high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge mclk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    pstrb_i <= s;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 16);
    if (pready_o !== 1'b1) begin
      fail_count++;
      end_of_test();
    end else begin
      // answer taken at the edge that samples ready high
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(negedge mclk_i);
    end
  endtask : apb

  task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000, 4'h0);
    cmp(what, 48'(exp), 48'(rd));
  endtask : rdchk

  function automatic cchp_pkg::cchp_core_act_t exp_act(input cchp_pkg::cchp_core_evt_t e, input logic [4:0] c);
    // c packs bfign, div0, unaln, usoft, thrd from high to low
    cchp_pkg::cchp_core_act_t a;
    logic mis;
    a = '0;
    mis = (e.access_size == cchp_pkg::SIZE_HALF) ? e.addr_low[0] : (e.addr_low[1:0] != 2'h0);
    a.div_trap = e.div_exec & e.div_by_zero & c[3];
    a.div_quot_zero = e.div_exec & e.div_by_zero & ~c[3];
    a.usage_fault = e.mem_access & (e.multi_or_double ? (e.addr_low[1:0] != 2'h0) : (c[2] & mis));
    a.lockup = e.bus_fault & e.neg_prio_handler & ~c[4];
    a.bus_fault_b_ignored = e.bus_fault & e.neg_prio_handler & c[4];
    a.soft_irq_trigger_reg_granted = e.soft_irq_trigger_reg_write & (e.privileged | c[1]);
    a.soft_irq_trigger_reg_denied = e.soft_irq_trigger_reg_write & ~(e.privileged | c[1]);
    a.thread_entry_ok = e.thread_return & (~e.other_active | c[0]);
    a.thread_entry_fault = e.thread_return & e.other_active & ~c[0];
    return a;
  endfunction : exp_act

  task automatic evchk(input cchp_pkg::cchp_core_evt_t e, input logic [4:0] c);
    @(posedge mclk_i);
    evt_i <= e;
    @(posedge mclk_i);
    evt_i <= '0;
    @(negedge mclk_i);
    cmp("act_o", 48'(exp_act(e, c)), 48'(act_o));
  endtask : evchk

  task automatic stk(input logic en, input logic rt, input logic [31:0] sp, input logic [31:0] program_status_word);
    @(posedge mclk_i);
    stack_req_i <= '{exc_entry: en, exception_return_value: rt, sp: sp, program_status_word: program_status_word};
    @(posedge mclk_i);
    stack_req_i <= '0;
    @(negedge mclk_i);
  endtask : stk

  initial begin
    repeat (20000) @(posedge mclk_i);
    fail_count++;
    end_of_test();
  end

  initial begin
    ev[0] = '{div_exec: 1'b1, div_by_zero: 1'b1, default: 0};
    ev[1] = '{mem_access: 1'b1, access_size: cchp_pkg::SIZE_HALF, addr_low: 3'h1, default: 0};
    ev[2] = '{mem_access: 1'b1, access_size: cchp_pkg::SIZE_WORD, addr_low: 3'h2, default: 0};
    ev[3] = '{mem_access: 1'b1, access_size: cchp_pkg::SIZE_WORD, addr_low: 3'h1, multi_or_double: 1'b1, default: 0};
    ev[4] = '{mem_access: 1'b1, access_size: cchp_pkg::SIZE_WORD, addr_low: 3'h4, default: 0};
    ev[5] = '{bus_fault: 1'b1, neg_prio_handler: 1'b1, default: 0};
    ev[6] = '{soft_irq_trigger_reg_write: 1'b1, default: 0};
    ev[7] = '{thread_return: 1'b1, other_active: 1'b1, default: 0};
    ev[8] = '{soft_irq_trigger_reg_write: 1'b1, privileged: 1'b1, thread_return: 1'b1, default: 0};
    repeat (6) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(negedge mclk_i);
    cmp("act_o idle", 48'h0, 48'(act_o));
    rdchk("ccr reset", cchp_pkg::OFF_CCR, 32'h00040200);
    apb(1'b1, cchp_pkg::OFF_CCR, 32'hFFFFFFFF, 4'hF);
    rdchk("ccr ones", cchp_pkg::OFF_CCR, 32'h0007031B);
    cmp("caches on", 48'h3, 48'({icache_on_o, dcache_on_o}));
    // lane two alone must leave the low lanes untouched
    apb(1'b1, cchp_pkg::OFF_CCR, 32'h00000000, 4'h4);
    rdchk("ccr lane2", cchp_pkg::OFF_CCR, 32'h0004031B);
    cmp("caches off", 48'h0, 48'({icache_on_o, dcache_on_o}));
    apb(1'b1, cchp_pkg::OFF_PRIO_A, 32'hFFFFFFFF, 4'h1);
    rdchk("prio a byte", cchp_pkg::OFF_PRIO_A, {24'h000000, PM});
    apb(1'b1, cchp_pkg::OFF_PRIO_A, 32'hA5C37E00, 4'hE);
    rdchk("prio a", cchp_pkg::OFF_PRIO_A, {8'h00, 8'hC3 & PM, 8'h7E & PM, PM});
    apb(1'b1, cchp_pkg::OFF_PRIO_SVC, 32'hFFFFFFFF, 4'hF);
    rdchk("prio svc", cchp_pkg::OFF_PRIO_SVC, {PM, 24'h000000});
    apb(1'b1, cchp_pkg::OFF_PRIO_TP, 32'h12345678, 4'hF);
    rdchk("prio tp", cchp_pkg::OFF_PRIO_TP, {8'h12 & PM, 8'h34 & PM, 16'h0000});
    cmp("prio_o", {8'h12 & PM, 8'h34 & PM, PM, 8'hC3 & PM, 8'h7E & PM, PM}, prio_o);
    apb(1'b1, 12'h010, 32'h00000000, 4'hF);
    cmp("pslverr", 48'h1, 48'(err));
    rdchk("svc kept", cchp_pkg::OFF_PRIO_SVC, {PM, 24'h000000});
    apb(1'b0, 12'h010, 32'h00000000, 4'h0);
    cmp("unmapped rd", 48'h0, 48'(rd));
    cmp("pslverr rd", 48'h1, 48'(err));
    for (int c = 0; c < 2; c++) begin
      apb(1'b1, cchp_pkg::OFF_CCR, (c == 1) ? 32'h0000011B : 32'h00000000, 4'hF);
      for (int i = 0; i < 9; i++) begin
        evchk(ev[i], (c == 1) ? 5'h1F : 5'h00);
      end
    end
    stk(1'b1, 1'b0, 32'h20001004, 32'h01000000);
    cmp("frame sp", 48'h20001000, 48'(frame_sp_o));
    cmp("psr padded", 48'h01000200, 48'(stacked_psr_o));
    stk(1'b1, 1'b0, 32'h20001008, 32'h01000200);
    cmp("psr unpadded", 48'h01000000, 48'(stacked_psr_o));
    stk(1'b0, 1'b1, 32'h20001020, 32'h01000200);
    cmp("sp restored", 48'h20001024, 48'(restored_sp_o));
    stk(1'b0, 1'b1, 32'h20001020, 32'h00000000);
    cmp("sp kept", 48'h20001020, 48'(restored_sp_o));
    // second reset in mid-run clears everything again
    @(posedge mclk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    rdchk("ccr rereset", cchp_pkg::OFF_CCR, 32'h00040200);
    rdchk("prio rereset", cchp_pkg::OFF_PRIO_A, 32'h00000000);
    cmp("prio_o rereset", 48'h0, prio_o);
    end_of_test();
  end
endmodule : tb
`default_nettype wire

// *** verilog/cchp_fault_policy.sv ***
// decision logic steered by the control word
`timescale 1ns/1ps
`default_nettype none
module cchp_fault_policy (
  // control bits
  input wire logic bfign_i,
  input wire logic div0_i,
  input wire logic unaln_i,
  input wire logic usoft_i,
  input wire logic thrd_i,
  // core events and decisions
  input wire cchp_pkg::cchp_core_evt_t evt_i,
  output cchp_pkg::cchp_core_act_t act_o
);
  logic misaligned;
  logic word_misaligned;

  always_comb begin
    word_misaligned = evt_i.addr_low[1:0] != 2'h0;
    misaligned = 1'b0;
    if (evt_i.access_size == cchp_pkg::SIZE_HALF) begin
      misaligned = evt_i.addr_low[0];
    end else if (evt_i.access_size == cchp_pkg::SIZE_WORD) begin
      misaligned = word_misaligned;
    end
    act_o.div_trap = evt_i.div_exec & evt_i.div_by_zero & div0_i; // [RULE6]
    act_o.div_quot_zero = evt_i.div_exec & evt_i.div_by_zero & ~div0_i; // [RULE6]
    act_o.usage_fault = evt_i.mem_access & ((evt_i.multi_or_double & word_misaligned) // [RULE8]
                        | (~evt_i.multi_or_double & misaligned & unaln_i)); // [RULE7]
    act_o.lockup = evt_i.bus_fault & evt_i.neg_prio_handler & ~bfign_i; // [RULE4]
    act_o.bus_fault_b_ignored = evt_i.bus_fault & evt_i.neg_prio_handler & bfign_i; // [RULE5]
    act_o.soft_irq_trigger_reg_granted = evt_i.soft_irq_trigger_reg_write & (evt_i.privileged | usoft_i); // [RULE9]
    act_o.soft_irq_trigger_reg_denied = evt_i.soft_irq_trigger_reg_write & ~evt_i.privileged & ~usoft_i; // [RULE9]
    act_o.thread_entry_ok = evt_i.thread_return & (~evt_i.other_active | thrd_i); // [RULE10] [RULE11]
    act_o.thread_entry_fault = evt_i.thread_return & evt_i.other_active & ~thrd_i; // [RULE10]
  end
endmodule : cchp_fault_policy
`default_nettype wire

// *** verilog/cchp_pkg.sv ***
// shared constants and carriers for the core control and handler priority block
//
// Functional notes
// [RULE1] Control bit 16 turns the level-one data cache off or on.
// [RULE2] Bit 9 is read-only, always one: exception entry aligns stack to 8 bytes.
// [RULE3] Entry records alignment padding in stacked status bit 9; return restores it.
// [RULE4] With bus-fault-ignore clear, data bus fault at priority -1/-2 locks up.
// [RULE5] With bus-fault-ignore set, priority -1/-2 handlers ignore data bus faults.
// [RULE6] Divide-by-zero trap set faults; clear completes with quotient zero.
// [RULE7] Misaligned trap set faults unaligned halfword/word accesses; clear lets them pass.
// [RULE8] Unaligned multiple-register and doubleword accesses always fault.
// [RULE9] Bit 1 grants or denies unprivileged access to the soft interrupt trigger.
// [RULE10] Thread-entry bit clear: return to thread only with no exception active.
// [RULE11] Thread-entry bit set: thread entry allowed from any active level.
// [RULE12] Priority registers hold levels 0 to 255 per configurable exception.
// [RULE13] All three priority registers accept byte-wide accesses.
// [RULE14] Only priority bits 7 down to M are stored; lower bits read zero.
// [RULE15] First priority word: usage 23:16, bus 15:8, memory 7:0, top byte reserved.
// [RULE16] Second priority word: supervisor call in 31:24, bits 23:0 reserved.
// [RULE17] Third priority word: tick 31:24, pendable service 23:16, 15:0 reserved.
// [RULE18] Bit 18 is read-only, always one: branch prediction enabled.
// [RULE19] Control bit 17 turns the level-one instruction cache off or on.
// [RULE20] Reserved bits read zero and ignore writes.
package cchp_pkg;

  localparam int unsigned ADDR_W = 12;

  localparam logic [11:0] OFF_CCR = 12'h000;
  localparam logic [11:0] OFF_PRIO_A = 12'h004;
  localparam logic [11:0] OFF_PRIO_SVC = 12'h008;
  localparam logic [11:0] OFF_PRIO_TP = 12'h00C;

  localparam int unsigned BIT_BPRED = 18;
  localparam int unsigned BIT_ICACHE = 17;
  localparam int unsigned BIT_DCACHE = 16;
  localparam int unsigned BIT_STKALN = 9;
  localparam int unsigned BIT_BFIGN = 8;
  localparam int unsigned BIT_DIV0 = 4;
  localparam int unsigned BIT_UNALN = 3;
  localparam int unsigned BIT_USOFT = 1;
  localparam int unsigned BIT_THRD = 0;

  localparam logic RST_CTRL_BIT = 1'h0;
  localparam logic [7:0] RST_PRIO = 8'h00;
  localparam int unsigned PRIO_BITS_DEF = 4;

  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;

  typedef struct packed {
    logic div_exec;
    logic div_by_zero;
    logic mem_access;
    logic [1:0] access_size;
    logic [2:0] addr_low;
    logic multi_or_double;
    logic bus_fault;
    logic neg_prio_handler;
    logic soft_irq_trigger_reg_write;
    logic privileged;
    logic thread_return;
    logic other_active;
  } cchp_core_evt_t;

  typedef struct packed {
    logic div_trap;
    logic div_quot_zero;
    logic usage_fault;
    logic lockup;
    logic bus_fault_b_ignored;
    logic soft_irq_trigger_reg_granted;
    logic soft_irq_trigger_reg_denied;
    logic thread_entry_ok;
    logic thread_entry_fault;
  } cchp_core_act_t;

  typedef struct packed {
    logic [7:0] tick;
    logic [7:0] pend;
    logic [7:0] svc;
    logic [7:0] usage;
    logic [7:0] bus;
    logic [7:0] memmgmt;
  } cchp_prio_t;

  typedef struct packed {
    logic exc_entry;
    logic exception_return_value;
    logic [31:0] sp;
    logic [31:0] program_status_word;
  } cchp_stack_req_t;

  typedef struct packed {
    logic [31:0] frame_sp;
    logic [31:0] stacked_psr;
    logic [31:0] restored_sp;
  } cchp_stack_rsp_t;

endpackage : cchp_pkg

// *** verilog/cchp_regs.sv ***
// control word and system handler priority registers behind an apb slave
//
// Chosen here: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module cchp_regs #(
  parameter int unsigned PRIO_BITS = cchp_pkg::PRIO_BITS_DEF
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // apb slave
  input wire logic [cchp_pkg::ADDR_W-1:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // cache enables
  output logic dcache_on_o,
  output logic icache_on_o,
  // priorities
  output cchp_pkg::cchp_prio_t prio_o,
  // core events and decisions
  input wire cchp_pkg::cchp_core_evt_t evt_i,
  output cchp_pkg::cchp_core_act_t act_o,
  // stack alignment
  input wire cchp_pkg::cchp_stack_req_t stack_req_i,
  output logic [31:0] frame_sp_o,
  output logic [31:0] stacked_psr_o,
  output logic [31:0] restored_sp_o
);

  // only bits 7 down to M exist; M = 8 - PRIO_BITS
  localparam logic [7:0] PRIO_MASK = 8'(8'hFF << (8 - PRIO_BITS));

  typedef struct packed {
    logic icache;
    logic dcache;
    logic bfign;
    logic div0;
    logic unaln;
    logic usoft;
    logic thrd;
    cchp_pkg::cchp_prio_t prio;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    cchp_pkg::cchp_core_act_t act;
    logic [31:0] frame_sp;
    logic [31:0] stacked_psr;
    logic [31:0] restored_sp;
  } cchp_state_t;

  cchp_state_t st_reg;
  cchp_state_t st_next;
  cchp_pkg::cchp_core_act_t act_comb;
  cchp_pkg::cchp_stack_rsp_t stack_comb;

  cchp_fault_policy u_policy (
    .bfign_i(st_reg.bfign),
    .div0_i(st_reg.div0),
    .unaln_i(st_reg.unaln),
    .usoft_i(st_reg.usoft),
    .thrd_i(st_reg.thrd),
    .evt_i(evt_i),
    .act_o(act_comb)
  );

  cchp_stack_align u_stack (
    .req_i(stack_req_i),
    .rsp_o(stack_comb)
  );

  function automatic logic mapped(input logic [cchp_pkg::ADDR_W-1:0] a);
    mapped = (a == cchp_pkg::OFF_CCR) || (a == cchp_pkg::OFF_PRIO_A) ||
             (a == cchp_pkg::OFF_PRIO_SVC) || (a == cchp_pkg::OFF_PRIO_TP);
  endfunction : mapped

  // byte lane merge, then drop the unimplemented low priority bits
  function automatic logic [7:0] prio_wr(input logic [7:0] old, input logic [7:0] wd,
                                         input logic en);
    prio_wr = en ? (wd & PRIO_MASK) : old; // [RULE13] [RULE14]
  endfunction : prio_wr

  function automatic logic [31:0] read_word(input logic [cchp_pkg::ADDR_W-1:0] a,
                                            input cchp_state_t s);
    logic [31:0] w;
    w = 32'h0; // [RULE20]
    case (a)
      cchp_pkg::OFF_CCR: begin
        w[cchp_pkg::BIT_BPRED] = 1'b1; // [RULE18]
        w[cchp_pkg::BIT_ICACHE] = s.icache;
        w[cchp_pkg::BIT_DCACHE] = s.dcache;
        w[cchp_pkg::BIT_STKALN] = 1'b1; // [RULE2]
        w[cchp_pkg::BIT_BFIGN] = s.bfign;
        w[cchp_pkg::BIT_DIV0] = s.div0;
        w[cchp_pkg::BIT_UNALN] = s.unaln;
        w[cchp_pkg::BIT_USOFT] = s.usoft;
        w[cchp_pkg::BIT_THRD] = s.thrd;
      end
      cchp_pkg::OFF_PRIO_A: begin
        w[23:0] = {s.prio.usage, s.prio.bus, s.prio.memmgmt}; // [RULE15]
      end
      cchp_pkg::OFF_PRIO_SVC: begin
        w[31:24] = s.prio.svc; // [RULE16]
      end
      cchp_pkg::OFF_PRIO_TP: begin
        w[31:16] = {s.prio.tick, s.prio.pend}; // [RULE17]
      end
      default: begin
        w = 32'h0;
      end
    endcase
    read_word = w;
  endfunction : read_word

  logic setup;
  logic wr_fire;

  always_comb begin
    setup = psel_i & ~penable_i;
    wr_fire = psel_i & penable_i & st_reg.pready & pwrite_i;
    st_next = st_reg;
    // zero-wait answer: ready rises in the access phase only
    st_next.pready = setup;
    if (setup) begin
      st_next.pslverr = ~mapped(paddr_i);
      st_next.prdata = pwrite_i ? 32'h0 : read_word(paddr_i, st_reg);
    end
    if (wr_fire) begin
      case (paddr_i)
        cchp_pkg::OFF_CCR: begin
          if (pstrb_i[2]) begin
            st_next.icache = pwdata_i[cchp_pkg::BIT_ICACHE]; // [RULE19]
            st_next.dcache = pwdata_i[cchp_pkg::BIT_DCACHE]; // [RULE1]
          end
          if (pstrb_i[1]) begin
            st_next.bfign = pwdata_i[cchp_pkg::BIT_BFIGN];
          end
          if (pstrb_i[0]) begin
            st_next.div0 = pwdata_i[cchp_pkg::BIT_DIV0];
            st_next.unaln = pwdata_i[cchp_pkg::BIT_UNALN];
            st_next.usoft = pwdata_i[cchp_pkg::BIT_USOFT];
            st_next.thrd = pwdata_i[cchp_pkg::BIT_THRD];
          end
        end
        cchp_pkg::OFF_PRIO_A: begin
          st_next.prio.memmgmt = prio_wr(st_reg.prio.memmgmt, pwdata_i[7:0], pstrb_i[0]); // [RULE15]
          st_next.prio.bus = prio_wr(st_reg.prio.bus, pwdata_i[15:8], pstrb_i[1]);
          st_next.prio.usage = prio_wr(st_reg.prio.usage, pwdata_i[23:16], pstrb_i[2]);
        end
        cchp_pkg::OFF_PRIO_SVC: begin
          st_next.prio.svc = prio_wr(st_reg.prio.svc, pwdata_i[31:24], pstrb_i[3]); // [RULE16]
        end
        cchp_pkg::OFF_PRIO_TP: begin
          st_next.prio.pend = prio_wr(st_reg.prio.pend, pwdata_i[23:16], pstrb_i[2]); // [RULE17]
          st_next.prio.tick = prio_wr(st_reg.prio.tick, pwdata_i[31:24], pstrb_i[3]); // [RULE12]
        end
        default: begin
          st_next.pslverr = st_reg.pslverr;
        end
      endcase
    end
    // decisions registered so every output leaves a flop
    st_next.act = act_comb;
    if (stack_req_i.exc_entry) begin
      st_next.frame_sp = stack_comb.frame_sp; // [RULE2]
      st_next.stacked_psr = stack_comb.stacked_psr; // [RULE3]
    end
    if (stack_req_i.exception_return_value) begin
      st_next.restored_sp = stack_comb.restored_sp; // [RULE3]
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= '0;
      st_reg.icache <= cchp_pkg::RST_CTRL_BIT;
      st_reg.dcache <= cchp_pkg::RST_CTRL_BIT;
      st_reg.bfign <= cchp_pkg::RST_CTRL_BIT;
      st_reg.div0 <= cchp_pkg::RST_CTRL_BIT;
      st_reg.unaln <= cchp_pkg::RST_CTRL_BIT;
      st_reg.usoft <= cchp_pkg::RST_CTRL_BIT;
      st_reg.thrd <= cchp_pkg::RST_CTRL_BIT;
      st_reg.prio <= {6{cchp_pkg::RST_PRIO}};
    end else begin
      st_reg <= st_next;
    end
  end

  assign prdata_o = st_reg.prdata;
  assign pready_o = st_reg.pready;
  assign pslverr_o = st_reg.pslverr;
  assign dcache_on_o = st_reg.dcache; // [RULE1]
  assign icache_on_o = st_reg.icache; // [RULE19]
  assign prio_o = st_reg.prio;
  assign act_o = st_reg.act;
  assign frame_sp_o = st_reg.frame_sp;
  assign stacked_psr_o = st_reg.stacked_psr;
  assign restored_sp_o = st_reg.restored_sp;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  logic rd_done;
  assign rd_done = psel_i & penable_i & pready_o & ~pwrite_i;

  a_ctrl_ro_ones: assert property ( // [RULE18]
    rd_done && paddr_i == cchp_pkg::OFF_CCR |-> prdata_o[18] && prdata_o[9] && prdata_o[31:19] == 13'h0)
    else $error("control word read lost its fixed one bits");

  a_dcache_write: assert property ( // [RULE1]
    wr_fire && paddr_i == cchp_pkg::OFF_CCR && pstrb_i[2] |=> dcache_on_o == $past(pwdata_i[16]))
    else $error("data cache enable did not follow the write");

  a_icache_write: assert property ( // [RULE19]
    wr_fire && paddr_i == cchp_pkg::OFF_CCR && pstrb_i[2] |=> icache_on_o == $past(pwdata_i[17]))
    else $error("instruction cache enable did not follow the write");

  a_lockup_on_fault: assert property ( // [RULE4]
    evt_i.bus_fault && evt_i.neg_prio_handler && !st_reg.bfign |=> act_o.lockup && !act_o.bus_fault_b_ignored)
    else $error("high priority bus fault did not lock up");

  a_bus_fault_b_ignored: assert property ( // [RULE5]
    evt_i.bus_fault && evt_i.neg_prio_handler && st_reg.bfign |=> !act_o.lockup && act_o.bus_fault_b_ignored)
    else $error("ignored bus fault still locked up");

  a_div_zero_trap: assert property ( // [RULE6]
    evt_i.div_exec && evt_i.div_by_zero |=> act_o.div_trap == $past(st_reg.div0) && act_o.div_quot_zero != act_o.div_trap)
    else $error("divide by zero handling does not match trap bit");

  a_multi_unaligned: assert property ( // [RULE8]
    evt_i.mem_access && evt_i.multi_or_double && evt_i.addr_low[1:0] != 2'h0 |=> act_o.usage_fault)
    else $error("unaligned multiple or doubleword access did not fault");

  a_soft_irq_trigger_reg_gate: assert property ( // [RULE9]
    evt_i.soft_irq_trigger_reg_write && !evt_i.privileged |=> act_o.soft_irq_trigger_reg_granted == $past(st_reg.usoft))
    else $error("unprivileged trigger access not gated by control bit");

  a_thread_entry: assert property ( // [RULE10]
    evt_i.thread_return && evt_i.other_active && !st_reg.thrd |=> act_o.thread_entry_fault && !act_o.thread_entry_ok)
    else $error("thread entry allowed with exception still active");

  a_prio_low_zero: assert property ( // [RULE14]
    (prio_o.svc & ~PRIO_MASK) == 8'h0 && (prio_o.tick & ~PRIO_MASK) == 8'h0 && (prio_o.bus & ~PRIO_MASK) == 8'h0)
    else $error("unimplemented priority bits hold a value");

  a_apb_one_wait: assert property (
    psel_i && !penable_i |=> pready_o ##1 !pready_o)
    else $error("apb ready not a single access-phase cycle");

  a_stack_pad_bit: assert property ( // [RULE3]
    stack_req_i.exc_entry |=> stacked_psr_o[9] == $past(stack_req_i.sp[2]) && frame_sp_o[2:0] == 3'h0)
    else $error("stacked status word does not record padding");

  a_half_unaligned: assert property ( // [RULE7]
    evt_i.mem_access && !evt_i.multi_or_double && evt_i.access_size == cchp_pkg::SIZE_HALF
    && evt_i.addr_low[0] |=> act_o.usage_fault == $past(st_reg.unaln))
    else $error("unaligned halfword trap wrong");

  a_word_unaligned: assert property ( // [RULE7]
    evt_i.mem_access && !evt_i.multi_or_double && evt_i.access_size == cchp_pkg::SIZE_WORD
    && evt_i.addr_low[1:0] != 2'h0 |=> act_o.usage_fault == $past(st_reg.unaln))
    else $error("unaligned word trap wrong");

  a_aligned_no_trap: assert property ( // [RULE7]
    evt_i.mem_access && !evt_i.multi_or_double && evt_i.access_size == cchp_pkg::SIZE_WORD
    && evt_i.addr_low[1:0] == 2'h0 |=> !act_o.usage_fault)
    else $error("aligned word access faulted");

  a_div_quotient: assert property ( // [RULE6]
    evt_i.div_exec && evt_i.div_by_zero && !st_reg.div0 |=> act_o.div_quot_zero && !act_o.div_trap)
    else $error("untrapped divide by zero not completed");

  a_soft_irq_trigger_reg_denied: assert property ( // [RULE9]
    evt_i.soft_irq_trigger_reg_write && !evt_i.privileged && !st_reg.usoft |=> act_o.soft_irq_trigger_reg_denied && !act_o.soft_irq_trigger_reg_granted)
    else $error("unprivileged trigger access not denied");

  a_soft_irq_trigger_reg_priv: assert property ( // [RULE9]
    evt_i.soft_irq_trigger_reg_write && evt_i.privileged |=> act_o.soft_irq_trigger_reg_granted && !act_o.soft_irq_trigger_reg_denied)
    else $error("privileged trigger access denied");

  a_thread_any: assert property ( // [RULE11]
    evt_i.thread_return && st_reg.thrd |=> act_o.thread_entry_ok && !act_o.thread_entry_fault)
    else $error("thread entry from any level refused");

  a_thread_idle: assert property ( // [RULE10]
    evt_i.thread_return && !evt_i.other_active |=> act_o.thread_entry_ok)
    else $error("thread entry with no active exception refused");

  a_bfign_write: assert property ( // [RULE4]
    wr_fire && paddr_i == cchp_pkg::OFF_CCR && pstrb_i[1] |=> st_reg.bfign == $past(pwdata_i[8]))
    else $error("bus fault ignore bit did not follow the write");

  a_lane0_trap: assert property ( // [RULE6]
    wr_fire && paddr_i == cchp_pkg::OFF_CCR && pstrb_i[0]
    |=> st_reg.div0 == $past(pwdata_i[4]) && st_reg.unaln == $past(pwdata_i[3]))
    else $error("trap bits did not follow the write");

  a_lane0_access: assert property ( // [RULE9]
    wr_fire && paddr_i == cchp_pkg::OFF_CCR && pstrb_i[0]
    |=> st_reg.usoft == $past(pwdata_i[1]) && st_reg.thrd == $past(pwdata_i[0]))
    else $error("access bits did not follow the write");

  a_ctrl_reserved: assert property ( // [RULE20]
    rd_done && paddr_i == cchp_pkg::OFF_CCR |-> prdata_o[15:10] == 6'h00 && prdata_o[7:5] == 3'h0 && !prdata_o[2])
    else $error("control word reserved bits not zero");

  a_prio_a_read: assert property ( // [RULE15]
    rd_done && paddr_i == cchp_pkg::OFF_PRIO_A |-> prdata_o[31:24] == 8'h00
    && prdata_o[23:0] == {prio_o.usage, prio_o.bus, prio_o.memmgmt})
    else $error("first priority word layout wrong");

  a_prio_svc_read: assert property ( // [RULE16]
    rd_done && paddr_i == cchp_pkg::OFF_PRIO_SVC |-> prdata_o == {prio_o.svc, 24'h000000})
    else $error("second priority word layout wrong");

  a_prio_tp_read: assert property ( // [RULE17]
    rd_done && paddr_i == cchp_pkg::OFF_PRIO_TP |-> prdata_o == {prio_o.tick, prio_o.pend, 16'h0000})
    else $error("third priority word layout wrong");

  a_prio_low_rest: assert property ( // [RULE14]
    ((prio_o.pend | prio_o.usage | prio_o.memmgmt) & ~PRIO_MASK) == 8'h00)
    else $error("unimplemented priority bits hold a value");

  a_prio_lane_keep: assert property ( // [RULE13]
    wr_fire && paddr_i == cchp_pkg::OFF_PRIO_A && !pstrb_i[0] |=> $stable(prio_o.memmgmt))
    else $error("unselected priority byte changed");

  a_tick_write: assert property ( // [RULE12]
    wr_fire && paddr_i == cchp_pkg::OFF_PRIO_TP && pstrb_i[3] |=> prio_o.tick == ($past(pwdata_i[31:24]) & PRIO_MASK))
    else $error("tick priority did not follow the write");

  a_unmapped_err: assert property ( // [RULE20]
    psel_i && !penable_i && !mapped(paddr_i) |=> pslverr_o && prdata_o == 32'h00000000)
    else $error("unmapped access not flagged");

  a_ready_idle: assert property (
    !psel_i |=> !pready_o)
    else $error("apb ready raised with no transfer");

  a_frame_sp: assert property ( // [RULE2]
    stack_req_i.exc_entry |=> frame_sp_o[31:3] == $past(stack_req_i.sp[31:3]))
    else $error("frame pointer lost its upper bits");

  a_restore_sp: assert property ( // [RULE3]
    stack_req_i.exception_return_value && stack_req_i.program_status_word[9]
    |=> restored_sp_o[2] && restored_sp_o[31:3] == $past(stack_req_i.sp[31:3]))
    else $error("padded stack not restored");

endmodule : cchp_regs
`default_nettype wire

// *** verilog/cchp_stack_align.sv ***
// eight-byte stack alignment on exception entry and its undo on return
`timescale 1ns/1ps
`default_nettype none
module cchp_stack_align (
  // stack request and result
  input wire cchp_pkg::cchp_stack_req_t req_i,
  output cchp_pkg::cchp_stack_rsp_t rsp_o
);
  logic pad;

  always_comb begin
    pad = req_i.sp[2];
    rsp_o.frame_sp = {req_i.sp[31:3], 3'h0}; // [RULE2]
    rsp_o.stacked_psr = req_i.program_status_word;
    rsp_o.stacked_psr[cchp_pkg::BIT_STKALN] = pad; // [RULE3]
    rsp_o.restored_sp = req_i.sp;
    rsp_o.restored_sp[2] = req_i.program_status_word[cchp_pkg::BIT_STKALN] | req_i.sp[2]; // [RULE3]
  end
endmodule : cchp_stack_align
`default_nettype wire
